// [rtl/audio_status_bank.sv]
// audio channel-status and clock regeneration readback register bank
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
//
// Contract
// - channel-status bit 0 is reported, 0 meaning consumer use.
// - category code reads at 0x5F, channel and source numbers at 0x60.
// - clock accuracy reads in bits 5:4 of 0x61 with its received code.
// - a 20-bit cycle time stamp is captured from the link.
// - the time stamp is split over 0x7B, 0x7C and the top nibble of 0x7D.
// - a 20-bit N is captured, its top four bits in 0x7D low nibble.
// - N bits 15:8 read at 0x7E and bits 7:0 at 0x7F, read-only.
// - channel-status bit 1 reports linear PCM (0) or other use (1).
// - only mode 00 is treated as defined, all other modes are reserved.
// - the write-block control bit stops packets updating N and stamp.
module audio_status_bank import audio_status_pkg::*; (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [DATA_W-1:0] S_AXI_WDATA,
	input wire logic [DATA_W/8-1:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [DATA_W-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic CS_VALID,
	input wire logic [CS_W-1:0] CS_BLOCK,
	input wire logic ACR_VALID,
	input wire logic [ACR_W-1:0] ACR_STAMP,
	input wire logic [ACR_W-1:0] ACR_DIVISOR,
	output logic [ACR_W-1:0] STAMP_OUT,
	output logic [ACR_W-1:0] DIVISOR_OUT,
	output logic ACR_BLOCKED
);
	regbus_if rb();

	logic [7:0] ctrl_q;
	logic [7:0] cs_basic_q;
	logic [7:0] category_q;
	logic [3:0] chan_num_q;
	logic [3:0] src_num_q;
	logic [1:0] accuracy_q;
	logic [3:0] rate_q;
	logic [3:0] word_len_q;
	logic cs_seen_q;
	logic acr_seen_q;
	logic mode_rsvd_q;
	logic acr_drop_q;
	logic [CNT_W-1:0] acr_count_q;
	logic [ACR_W-1:0] stamp;
	logic [ACR_W-1:0] divisor;
	logic acr_taken;
	logic acr_dropped;

	function automatic logic idx_readable(input logic [IDX_W-1:0] idx);
		idx_readable = (idx == IDX_LINK_CTRL) || (idx == IDX_CS_BASIC) ||
			(idx == IDX_CATEGORY) || (idx == IDX_CHAN_SRC) ||
			(idx == IDX_ACC_RATE) || (idx == IDX_WORD_LEN) ||
			(idx == IDX_LINK_STAT) || (idx == IDX_ACR_COUNT) ||
			(idx >= IDX_CTS_HIGH && idx <= IDX_N_LOW);
	endfunction

	function automatic logic idx_writable(input logic [IDX_W-1:0] idx);
		idx_writable = (idx == IDX_LINK_CTRL) || (idx == IDX_LINK_STAT);
	endfunction

	axil_reg_slave u_slave (
		.clk(CLK_SYS),
		.reset(RESET),
		.awaddr(S_AXI_AWADDR),
		.awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY),
		.wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB),
		.wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY),
		.bresp(S_AXI_BRESP),
		.bvalid(S_AXI_BVALID),
		.bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR),
		.arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY),
		.rdata(S_AXI_RDATA),
		.rresp(S_AXI_RRESP),
		.rvalid(S_AXI_RVALID),
		.rready(S_AXI_RREADY),
		.rb(rb.bus)
	);

	acr_capture #(.VAL_W(ACR_W)) u_acr (
		.clk(CLK_SYS),
		.reset(RESET),
		.pkt_valid(ACR_VALID),
		.pkt_stamp(ACR_STAMP),
		.pkt_divisor(ACR_DIVISOR),
		.block(ctrl_q[CTRL_BLOCK_BIT]),
		.stamp_q(stamp),
		.divisor_q(divisor),
		.taken(acr_taken),
		.dropped(acr_dropped)
	);

	assign STAMP_OUT = stamp;
	assign DIVISOR_OUT = divisor;
	assign ACR_BLOCKED = ctrl_q[CTRL_BLOCK_BIT];

	// write decode
	wire ctrl_wr = rb.wr_req && rb.wr_lane && rb.wr_index == IDX_LINK_CTRL;
	wire stat_wr = rb.wr_req && rb.wr_lane && rb.wr_index == IDX_LINK_STAT;
	assign rb.wr_ok = idx_writable(rb.wr_index);

	// received block fields
	wire [1:0] cs_mode = CS_BLOCK[CS_MODE_LSB +: 2];
	wire cs_mode_ok = cs_mode == CS_MODE_DEFINED;
	wire cs_take = CS_VALID && cs_mode_ok;
	wire cs_reject = CS_VALID && !cs_mode_ok;

	// status flags: write one clears, a new event wins over the clear
	wire clr_cs_seen = stat_wr && rb.wr_data[STAT_CS_SEEN_BIT];
	wire clr_acr_seen = stat_wr && rb.wr_data[STAT_ACR_SEEN_BIT];
	wire clr_mode_rsvd = stat_wr && rb.wr_data[STAT_MODE_RSVD_BIT];
	wire clr_acr_drop = stat_wr && rb.wr_data[STAT_ACR_DROP_BIT];

	wire [7:0] link_stat = {4'h0, acr_drop_q, mode_rsvd_q, acr_seen_q,
		cs_seen_q};
	wire [7:0] chan_src = {chan_num_q, src_num_q};
	wire [7:0] acc_rate = {2'h0, accuracy_q, rate_q};
	wire [7:0] word_len = {4'h0, word_len_q};
	wire [7:0] cts_low_n_high = {stamp[3:0], divisor[19:16]};

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			ctrl_q <= CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_q <= rb.wr_data;
		end
	end

	// basic byte always kept so software can see a reserved mode
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			cs_basic_q <= FIELD_RESET;
		end else if (CS_VALID) begin
			cs_basic_q <= CS_BLOCK[7:0];
		end
	end

	// remaining fields only from blocks in the defined mode
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			category_q <= FIELD_RESET;
			chan_num_q <= 4'h0;
			src_num_q <= 4'h0;
			accuracy_q <= ACC_LEVEL_TWO;
			rate_q <= FS_44K1;
			word_len_q <= 4'h0;
		end else if (cs_take) begin
			category_q <= CS_BLOCK[CS_CAT_LSB +: 8];
			chan_num_q <= CS_BLOCK[CS_CHAN_LSB +: 4];
			src_num_q <= CS_BLOCK[CS_SRC_LSB +: 4];
			accuracy_q <= CS_BLOCK[CS_ACC_LSB +: 2];
			rate_q <= CS_BLOCK[CS_FS_LSB +: 4];
			word_len_q <= CS_BLOCK[CS_WL_LSB +: 4];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			cs_seen_q <= 1'b0;
			acr_seen_q <= 1'b0;
			mode_rsvd_q <= 1'b0;
			acr_drop_q <= 1'b0;
		end else begin
			cs_seen_q <= cs_take || (cs_seen_q && !clr_cs_seen);
			acr_seen_q <= acr_taken || (acr_seen_q && !clr_acr_seen);
			mode_rsvd_q <= cs_reject || (mode_rsvd_q && !clr_mode_rsvd);
			acr_drop_q <= acr_dropped || (acr_drop_q && !clr_acr_drop);
		end
	end

	// counts accepted clock regeneration packets, wraps
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			acr_count_q <= '0;
		end else if (acr_taken) begin
			acr_count_q <= acr_count_q + 1'b1;
		end
	end

	// read mux
	wire [IDX_W-1:0] ri = rb.rd_index;
	assign rb.rd_ok = idx_readable(ri);
	assign rb.rd_data =
		(ri == IDX_LINK_CTRL) ? ctrl_q :
		(ri == IDX_CS_BASIC) ? cs_basic_q :
		(ri == IDX_CATEGORY) ? category_q :
		(ri == IDX_CHAN_SRC) ? chan_src :
		(ri == IDX_ACC_RATE) ? acc_rate :
		(ri == IDX_WORD_LEN) ? word_len :
		(ri == IDX_LINK_STAT) ? link_stat :
		(ri == IDX_ACR_COUNT) ? acr_count_q :
		(ri == IDX_CTS_HIGH) ? stamp[19:12] :
		(ri == IDX_CTS_MID) ? stamp[11:4] :
		(ri == IDX_CTS_LOW_N_HIGH) ? cts_low_n_high :
		(ri == IDX_N_MID) ? divisor[15:8] :
		(ri == IDX_N_LOW) ? divisor[7:0] :
		8'h00;
endmodule

// [rtl/audio_status_pkg.sv]
// constants for the audio status and clock regeneration readback bank
package audio_status_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = 10;
	localparam int CS_W = 40;
	localparam int ACR_W = 20;
	localparam int CNT_W = 8;

	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_LINK_CTRL = 10'h058;
	localparam logic [IDX_W-1:0] IDX_CS_BASIC = 10'h05e;
	localparam logic [IDX_W-1:0] IDX_CATEGORY = 10'h05f;
	localparam logic [IDX_W-1:0] IDX_CHAN_SRC = 10'h060;
	localparam logic [IDX_W-1:0] IDX_ACC_RATE = 10'h061;
	localparam logic [IDX_W-1:0] IDX_WORD_LEN = 10'h062;
	localparam logic [IDX_W-1:0] IDX_LINK_STAT = 10'h070;
	localparam logic [IDX_W-1:0] IDX_ACR_COUNT = 10'h071;
	localparam logic [IDX_W-1:0] IDX_CTS_HIGH = 10'h07b;
	localparam logic [IDX_W-1:0] IDX_CTS_MID = 10'h07c;
	localparam logic [IDX_W-1:0] IDX_CTS_LOW_N_HIGH = 10'h07d;
	localparam logic [IDX_W-1:0] IDX_N_MID = 10'h07e;
	localparam logic [IDX_W-1:0] IDX_N_LOW = 10'h07f;

	// channel-status bit positions in the received block
	localparam int CS_PRO_BIT = 0;
	localparam int CS_NONPCM_BIT = 1;
	localparam int CS_COPY_BIT = 2;
	localparam int CS_EMPH_LSB = 3;
	localparam int CS_MODE_LSB = 6;
	localparam int CS_CAT_LSB = 8;
	localparam int CS_SRC_LSB = 16;
	localparam int CS_CHAN_LSB = 20;
	localparam int CS_FS_LSB = 24;
	localparam int CS_ACC_LSB = 28;
	localparam int CS_WL_LSB = 32;

	localparam logic [1:0] CS_MODE_DEFINED = 2'h0;
	localparam logic [1:0] ACC_LEVEL_TWO = 2'h0;
	localparam logic [1:0] ACC_LEVEL_THREE = 2'h1;
	localparam logic [1:0] ACC_LEVEL_ONE = 2'h2;
	localparam logic [3:0] FS_44K1 = 4'h0;
	localparam logic [3:0] FS_48K = 4'h2;
	localparam logic [3:0] FS_88K2 = 4'h8;
	localparam logic [3:0] FS_96K = 4'ha;
	localparam logic [3:0] FS_176K4 = 4'hc;
	localparam logic [3:0] FS_192K = 4'he;

	// control and status field positions
	localparam int CTRL_BLOCK_BIT = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int STAT_CS_SEEN_BIT = 0;
	localparam int STAT_ACR_SEEN_BIT = 1;
	localparam int STAT_MODE_RSVD_BIT = 2;
	localparam int STAT_ACR_DROP_BIT = 3;
	localparam logic [7:0] FIELD_RESET = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/regbus_if.sv]
// internal register access path between bus slave and register bank
`timescale 1ns/1ps
interface regbus_if;
	import audio_status_pkg::*;
	logic wr_req;
	logic [IDX_W-1:0] wr_index;
	logic [7:0] wr_data;
	logic wr_lane;
	logic wr_ok;
	logic rd_req;
	logic [IDX_W-1:0] rd_index;
	logic [7:0] rd_data;
	logic rd_ok;
	modport bus(output wr_req, wr_index, wr_data, wr_lane, rd_req, rd_index,
		input wr_ok, rd_data, rd_ok);
	modport bank(input wr_req, wr_index, wr_data, wr_lane, rd_req, rd_index,
		output wr_ok, rd_data, rd_ok);
endinterface

// [rtl/axil_reg_slave.sv]
// axi4-lite slave front end onto the internal register path
`timescale 1ns/1ps
module axil_reg_slave import audio_status_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [DATA_W/8-1:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	regbus_if.bus rb
);
	logic aw_held_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic w_held_q;
	logic [7:0] w_data_q;
	logic w_lane_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	wire wr_fire = aw_held_q && w_held_q;
	wire rd_fire = arvalid && arready;

	// address and data taken in either order, held until both present
	assign awready = !aw_held_q && !bvalid_q;
	assign wready = !w_held_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign rb.wr_req = wr_fire;
	assign rb.wr_index = aw_addr_q[ADDR_W-1:2];
	assign rb.wr_data = w_data_q;
	assign rb.wr_lane = w_lane_q;
	assign rb.rd_req = rd_fire;
	assign rb.rd_index = araddr[ADDR_W-1:2];

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
			w_held_q <= 1'b0;
			w_data_q <= 8'h00;
			w_lane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_q <= 1'b1;
				w_data_q <= wdata[7:0];
				w_lane_q <= wstrb[0];
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= rb.wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q <= {{(DATA_W-8){1'b0}}, rb.rd_data};
			rresp_q <= rb.rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule

// [rtl/acr_capture.sv]
// captures clock regeneration values unless software blocks updates
`timescale 1ns/1ps
module acr_capture import audio_status_pkg::*; #(
	parameter int VAL_W = ACR_W
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic pkt_valid,
	input wire logic [VAL_W-1:0] pkt_stamp,
	input wire logic [VAL_W-1:0] pkt_divisor,
	input wire logic block,
	output logic [VAL_W-1:0] stamp_q,
	output logic [VAL_W-1:0] divisor_q,
	output logic taken,
	output logic dropped
);
	assign taken = pkt_valid && !block;
	assign dropped = pkt_valid && block;

	always_ff @(posedge clk) begin
		if (reset) begin
			stamp_q <= '0;
			divisor_q <= '0;
		end else if (taken) begin
			stamp_q <= pkt_stamp;
			divisor_q <= pkt_divisor;
		end
	end
endmodule

// [dv/audio_status_bank_assertions.sv]
// port checks for the audio status readback bank
`timescale 1ns/1ps
module audio_status_bank_assertions import audio_status_pkg::*; (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [DATA_W-1:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic ACR_VALID,
	input wire logic [ACR_W-1:0] ACR_STAMP,
	input wire logic [ACR_W-1:0] ACR_DIVISOR,
	input wire logic [ACR_W-1:0] STAMP_OUT,
	input wire logic [ACR_W-1:0] DIVISOR_OUT,
	input wire logic ACR_BLOCKED
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	sequence wr_both;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence ro_wr;
		wr_both ##0 (S_AXI_AWADDR[11:2] inside
			{[IDX_CS_BASIC:IDX_WORD_LEN], [IDX_CTS_HIGH:IDX_N_LOW]});
	endsequence
	chk_stamp_take: assert property (ACR_VALID && !ACR_BLOCKED |=>
		STAMP_OUT == $past(ACR_STAMP)) else $error("stamp not captured");
	chk_divisor_take: assert property (ACR_VALID && !ACR_BLOCKED |=>
		DIVISOR_OUT == $past(ACR_DIVISOR)) else $error("n not captured");
	chk_block_holds: assert property (ACR_VALID && ACR_BLOCKED |=>
		$stable(STAMP_OUT) && $stable(DIVISOR_OUT))
		else $error("blocked packet changed values");
	chk_idle_holds: assert property (!ACR_VALID |=>
		$stable(STAMP_OUT) && $stable(DIVISOR_OUT))
		else $error("values changed without packet");
	chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
		S_AXI_RVALID) else $error("read not answered");
	chk_read_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data moved");
	chk_byte_wide: assert property (S_AXI_RVALID |->
		S_AXI_RDATA[31:8] == 24'h0) else $error("upper read bits set");
	chk_ro_refused: assert property (ro_wr |-> ##[1:2]
		(S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR))
		else $error("read-only write accepted");
endmodule

// [dv/link_source.sv]
// model of the link source sending status and clock packets
`timescale 1ns/1ps
module link_source import audio_status_pkg::*; (
	input wire logic clk,
	output logic cs_valid,
	output logic [CS_W-1:0] cs_block,
	output logic acr_valid,
	output logic [ACR_W-1:0] acr_stamp,
	output logic [ACR_W-1:0] acr_divisor
);
	initial begin
		cs_valid = 1'b0;
		acr_valid = 1'b0;
		cs_block = '0;
		acr_stamp = '0;
		acr_divisor = '0;
	end
	// data lines invert once the pulse is over
	task automatic send_cs(input logic [CS_W-1:0] b);
		cs_block <= b;
		cs_valid <= 1'b1;
		@(posedge clk);
		cs_valid <= 1'b0;
		cs_block <= ~b;
	endtask
	task automatic send_acr(input logic [ACR_W-1:0] s,
		input logic [ACR_W-1:0] n);
		acr_stamp <= s;
		acr_divisor <= n;
		acr_valid <= 1'b1;
		@(posedge clk);
		acr_valid <= 1'b0;
		acr_stamp <= ~s;
		acr_divisor <= ~n;
	endtask
endmodule

// [dv/tb.sv]
// self-checking bench for the audio status readback bank
`timescale 1ns/1ps
module tb import audio_status_pkg::*; ();
	logic clk, rst, awv, wv, bready, arv, rready;
	logic awready, wready, bvalid, rvalid, arready, blocked;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic cs_valid, acr_valid;
	logic [CS_W-1:0] cs_block, cs_sh, b;
	logic [ACR_W-1:0] acr_stamp, acr_div, st_out, dv_out, st_sh, dv_sh, s, n;
	logic [7:0] b0_sh;
	int err_total, n_compared;
	logic [IDX_W-1:0] regs [10] = '{IDX_CS_BASIC, IDX_CATEGORY, IDX_CHAN_SRC,
		IDX_ACC_RATE, IDX_WORD_LEN, IDX_CTS_HIGH, IDX_CTS_MID,
		IDX_CTS_LOW_N_HIGH, IDX_N_MID, IDX_N_LOW};
	logic [3:0] fs_tab [6] = '{FS_44K1, FS_48K, FS_88K2, FS_96K, FS_176K4,
		FS_192K};
	audio_status_bank audio_status_bank_i (.CLK_SYS(clk), .RESET(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CS_VALID(cs_valid),
		.CS_BLOCK(cs_block), .ACR_VALID(acr_valid), .ACR_STAMP(acr_stamp),
		.ACR_DIVISOR(acr_div), .STAMP_OUT(st_out), .DIVISOR_OUT(dv_out),
		.ACR_BLOCKED(blocked));
	link_source src_i (.clk(clk), .cs_valid(cs_valid), .cs_block(cs_block),
		.acr_valid(acr_valid), .acr_stamp(acr_stamp), .acr_divisor(acr_div));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [7:0] exp_reg(input logic [IDX_W-1:0] i);
		case (i)
			IDX_CS_BASIC: return b0_sh;
			IDX_CATEGORY: return cs_sh[15:8];
			IDX_CHAN_SRC: return cs_sh[23:16];
			IDX_ACC_RATE: return {2'h0, cs_sh[29:24]};
			IDX_WORD_LEN: return {4'h0, cs_sh[35:32]};
			IDX_CTS_HIGH: return st_sh[19:12];
			IDX_CTS_MID: return st_sh[11:4];
			IDX_CTS_LOW_N_HIGH: return {st_sh[3:0], dv_sh[19:16]};
			IDX_N_MID: return dv_sh[15:8];
			default: return dv_sh[7:0];
		endcase
	endfunction
	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic axi_wr(input logic [IDX_W-1:0] i, input logic [7:0] v);
		logic a, w;
		a = 1'b0;
		w = 1'b0;
		awaddr <= {i, 2'b00};
		wdata <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		while (!(a && w)) begin
			@(negedge clk);
			a = a | awready;
			w = w | wready;
			@(posedge clk);
			if (a) awv <= 1'b0;
			if (w) wv <= 1'b0;
		end
		do @(negedge clk); while (!bvalid);
		r = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [IDX_W-1:0] i);
		int w;
		w = $urandom % 3;
		araddr <= {i, 2'b00};
		arv <= 1'b1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arv <= 1'b0;
		// random stall on the answer so held read data is exercised
		repeat (w) @(posedge clk);
		rready <= 1'b1;
		do @(negedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	task automatic check_all(input string nm);
		foreach (regs[k]) begin
			axi_rd(regs[k]);
			cmp("reg", {24'h0, exp_reg(regs[k])}, d);
			cmp("read response", {30'h0, RESP_OKAY}, {30'h0, r});
		end
		cmp("stamp", {12'h0, st_sh}, {12'h0, st_out});
		cmp("divisor", {12'h0, dv_sh}, {12'h0, dv_out});
		$display("test %s done", nm);
	endtask
	task automatic acr(input logic [ACR_W-1:0] s0, input logic [ACR_W-1:0] n0);
		src_i.send_acr(s0, n0);
		if (blocked !== 1'b1) begin
			st_sh = s0;
			dv_sh = n0;
		end
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude();
	end
	initial begin
		{rst, awv, wv, bready, arv, rready} = 6'h20;
		{awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'h1};
		{cs_sh, b0_sh, st_sh, dv_sh} = '0;
		err_total = 0;
		n_compared = 0;
		void'($urandom(32'h9e92df28));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check_all("reset");
		for (int k = 0; k < 12; k++) begin
			b = CS_W'({$urandom, $urandom});
			b[7:6] = (k == 5 || k == 11) ? k[1:0] : 2'h0;
			{b[29:24], b[1:0]} = {k[1:0], fs_tab[k % 6], k[1:0]};
			src_i.send_cs(b);
			b0_sh = b[7:0];
			if (b[7:6] == 2'h0) cs_sh = b;
			check_all("status block");
		end
		axi_rd(IDX_LINK_STAT);
		cmp("status", 32'h5, d);
		axi_wr(IDX_LINK_STAT, 8'h0f);
		cmp("status response", {30'h0, RESP_OKAY}, {30'h0, r});
		axi_rd(IDX_LINK_STAT);
		cmp("status cleared", 32'h0, d);
		for (int k = 0; k < 6; k++) begin
			s = (k == 0) ? 20'hfffff : ACR_W'($urandom);
			n = (k == 1) ? 20'h80001 : ACR_W'($urandom);
			if (k == 2) begin
				acr(ACR_W'($urandom), ACR_W'($urandom));
				@(posedge clk);
			end
			acr(s, n);
			check_all("clock packet");
		end
		axi_wr(IDX_LINK_CTRL, 8'h08);
		cmp("control response", {30'h0, RESP_OKAY}, {30'h0, r});
		cmp("blocked", 32'h1, {31'h0, blocked});
		acr(ACR_W'($urandom), ACR_W'($urandom));
		check_all("blocked packet");
		axi_wr(IDX_LINK_CTRL, 8'h00);
		acr(20'h12345, 20'habcde);
		check_all("unblocked packet");
		axi_wr(IDX_N_LOW, 8'h55);
		cmp("read-only write", {30'h0, RESP_SLVERR}, {30'h0, r});
		axi_rd(10'h3ff);
		cmp("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
		cmp("unmapped data", 32'h0, d);
		check_all("refused access");
		axi_rd(IDX_ACR_COUNT);
		cmp("packet count", 32'h8, d);
		axi_rd(IDX_LINK_STAT);
		cmp("status", 32'ha, d);
		conclude();
	end
endmodule
bind audio_status_bank audio_status_bank_assertions chk_i (
	.CLK_SYS(CLK_SYS), .RESET(RESET), .S_AXI_AWADDR(S_AXI_AWADDR),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .ACR_VALID(ACR_VALID),
	.ACR_STAMP(ACR_STAMP), .ACR_DIVISOR(ACR_DIVISOR),
	.STAMP_OUT(STAMP_OUT), .DIVISOR_OUT(DIVISOR_OUT),
	.ACR_BLOCKED(ACR_BLOCKED));
